// >>> design/ddc_ctrl.sv
/*
 DDR SDRAM controller: registered user command port, sequencer, forwarded
 memory clock, centred write strobe and read capture on the system clock.
 Assumes user logic supplies refresh commands and a DDR SDRAM on the pins.
*/
`timescale 1ns/1ps
module ddc_ctrl import ddc_pkg::*; #(
	parameter int DQ_W  = 64,
	parameter int DQS_W = DQ_W / 32
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	input  wire logic [CMD_W-1:0]     user_cmd_i,
	input  wire logic [UADDR_W-1:0]   user_addr_i,
	input  wire logic [2*DQ_W-1:0]    user_wdata_i,
	output logic                      user_cmd_ready_o,
	output logic                      user_wdata_take_o,
	output logic [2*DQ_W-1:0]         user_rdata_o,
	output logic                      user_rdata_valid_o,
	output logic                      user_refresh_ack_o,
	output logic                      test_mode_select_o,
	input  wire logic                 clock_feedback_in_i,
	output logic                      clock_feedback_locked_o,
	output logic                      mem_clk_o,
	output logic                      mem_clk_n_o,
	output logic                      mem_cke_o,
	output logic                      mem_cs_n_o,
	output logic                      mem_ras_n_o,
	output logic                      mem_cas_n_o,
	output logic                      mem_we_n_o,
	output logic [1:0]                mem_ba_o,
	output logic [11:0]               mem_addr_o,
	output logic [DQS_W-1:0]          mem_byte_mask_o,
	input  wire logic [DQ_W-1:0]      mem_dq_i,
	output logic [DQ_W-1:0]           mem_dq_o,
	output logic                      mem_dq_oe_o,
	input  wire logic [DQS_W-1:0]     mem_dqs_i,
	output logic [DQS_W-1:0]          mem_dqs_o,
	output logic                      mem_dqs_oe_o
);

if (DQ_W % 32 != 0 || DQ_W < 32 || DQS_W != DQ_W / 32 || RCD_CYCLES < 2) begin : g_chk
	$error("ddc_ctrl: unsupported DQ_W, DQS_W or row-column delay");
end

////////////////////////////////////////////////////////////////////////////////
// Functions

function automatic logic [4:0] burst_beats(input logic [2:0] code);
	unique case (code)
		BL_CODE_2: burst_beats = 5'h02;
		BL_CODE_8: burst_beats = 5'h08;
		default:   burst_beats = 5'h04;
	endcase
endfunction

// Read latency in memory half-cycles
function automatic logic [5:0] cas_halves(input logic [2:0] code);
	unique case (code)
		CL_CODE_2:  cas_halves = 6'h04;
		CL_CODE_25: cas_halves = 6'h05;
		default:    cas_halves = 6'h06;
	endcase
endfunction

function automatic logic cmd_known(input logic [CMD_W-1:0] c);
	cmd_known = (c == CMD_MODE_LOAD) || (c == CMD_READ_AC) || (c == CMD_WRITE_AC) ||
	            (c == CMD_PRECHARGE) || (c == CMD_REFRESH);
endfunction

////////////////////////////////////////////////////////////////////////////////
// Declarations

logic [1:0]           ph_q;
logic                 tick;
logic [CMD_W-1:0]     cmd_q;
logic [UADDR_W-1:0]   addr_q;
logic [2*DQ_W-1:0]    wdata_q;
logic                 accept;
logic                 ready_q;
logic                 pend_q;
logic [CMD_W-1:0]     pcmd_q;
logic [UADDR_W-1:0]   paddr_q;
ddc_state_t           st_q;
ddc_state_t           st_d;
logic [1:0]           rcd_q;
logic                 stop_q;
logic [2:0]           bl_q;
logic [2:0]           cl_q;
logic [4:0]           beats;
logic [5:0]           wcnt_q;
logic                 wr_busy_q;
logic [2*DQ_W-1:0]    wbuf_q;
logic [5:0]           rcnt_q;
logic                 rd_busy_q;
logic [4:0]           rbeat_q;
logic [DQ_W-1:0]      dq_s1_q;
logic [DQ_W-1:0]      dq_s2_q;
logic [DQ_W-1:0]      dq_s3_q;
logic [DQ_W-1:0]      rhi_q;
logic [2:0]           fb_q;
logic [2:0]           fb_cnt_q;
logic                 fb_lvl_q;
logic [5:0]           clh;

assign tick   = ce_i && (ph_q == 2'd1);
assign beats  = burst_beats(bl_q);
assign clh    = cas_halves(cl_q);
assign accept = ce_i && ready_q && cmd_known(cmd_q);

assign user_cmd_ready_o = ready_q;

////////////////////////////////////////////////////////////////////////////////
// Forwarded memory clock: four system cycles per memory cycle

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		ph_q        <= 2'd0;
		mem_clk_o   <= 1'b0;
		mem_clk_n_o <= 1'b1;
	end else if (ce_i) begin
		ph_q        <= ph_q + 2'd1;
		mem_clk_o   <= (ph_q == 2'd3) || (ph_q == 2'd0);
		mem_clk_n_o <= !((ph_q == 2'd3) || (ph_q == 2'd0));
	end
end

////////////////////////////////////////////////////////////////////////////////
// User input registers and command acceptance

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		cmd_q   <= CMD_NOP;
		addr_q  <= '0;
		wdata_q <= '0;
	end else if (ce_i) begin
		cmd_q   <= user_cmd_i;
		addr_q  <= user_addr_i;
		wdata_q <= user_wdata_i;
	end
end

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		pend_q  <= 1'b0;
		pcmd_q  <= CMD_NOP;
		paddr_q <= '0;
	end else if (accept) begin
		pend_q  <= 1'b1;
		pcmd_q  <= cmd_q;
		paddr_q <= addr_q;
	end else if (tick && st_q == S_IDLE) begin
		pend_q  <= 1'b0;
	end
end

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		ready_q <= 1'b0;
	end else if (ce_i) begin
		ready_q <= !accept && !pend_q && st_q == S_IDLE && !wr_busy_q && !rd_busy_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer, advanced once per memory cycle

always_comb begin
	st_d = st_q;
	if (tick) begin
		unique case (st_q)
			S_IDLE: begin
				if (pend_q) begin
					unique case (pcmd_q)
						CMD_MODE_LOAD: st_d = S_MODE;
						CMD_REFRESH:   st_d = S_REF;
						CMD_PRECHARGE: st_d = S_PRE;
						default:       st_d = S_ACT;
					endcase
				end
			end
			S_ACT:  st_d = S_RCD;
			S_RCD: begin
				if (rcd_q == 2'd0) begin
					st_d = (pcmd_q == CMD_READ_AC) ? S_READ : S_WRITE;
				end
			end
			S_READ:  st_d = S_RD_DATA;
			S_WRITE: st_d = S_WR_DATA;
			S_RD_DATA: begin
				if (stop_q) begin
					st_d = S_BST;
				end else if (!rd_busy_q) begin
					st_d = S_IDLE;
				end
			end
			S_WR_DATA: begin
				if (stop_q) begin
					st_d = S_BST;
				end else if (!wr_busy_q) begin
					st_d = S_IDLE;
				end
			end
			S_MODE, S_REF, S_PRE, S_BST: st_d = S_IDLE;
		endcase
	end
end

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		st_q  <= S_IDLE;
		rcd_q <= 2'd0;
	end else if (tick) begin
		st_q <= st_d;
		if (st_d == S_RCD && st_q == S_ACT) begin
			rcd_q <= 2'(RCD_CYCLES - 2);
		end else if (rcd_q != 2'd0) begin
			rcd_q <= rcd_q - 2'd1;
		end
	end
end

// Burst stop is caught at any time during an access; a new stop beats the clear
always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		stop_q <= 1'b0;
	end else if (ce_i) begin
		if (cmd_q == CMD_BURST_STOP && st_q != S_IDLE && st_q != S_BST) begin
			stop_q <= 1'b1;
		end else if (tick && (st_d == S_BST || st_d == S_IDLE)) begin
			stop_q <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Command pins, updated on the falling memory clock edge

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		mem_cke_o       <= 1'b0;
		mem_cs_n_o      <= 1'b0;
		mem_ras_n_o     <= 1'b1;
		mem_cas_n_o     <= 1'b1;
		mem_we_n_o      <= 1'b1;
		mem_ba_o        <= 2'd0;
		mem_addr_o      <= 12'h000;
		mem_byte_mask_o <= '0;
	end else if (tick) begin
		mem_cke_o   <= 1'b1;
		mem_ras_n_o <= 1'b1;
		mem_cas_n_o <= 1'b1;
		mem_we_n_o  <= 1'b1;
		if (st_d != st_q) begin
			unique case (st_d)
				S_ACT: begin
					mem_ras_n_o <= 1'b0;
					mem_ba_o    <= paddr_q[BA_LSB +: 2];
					mem_addr_o  <= paddr_q[ROW_LSB +: 12];
				end
				S_READ, S_WRITE: begin
					mem_cas_n_o <= 1'b0;
					mem_we_n_o  <= (st_d == S_READ);
					mem_ba_o    <= paddr_q[BA_LSB +: 2];
					mem_addr_o  <= 12'h000;
					mem_addr_o[COL_W-1:0]     <= paddr_q[COL_W-1:0];
					mem_addr_o[AUTOCLOSE_BIT] <= 1'b1;
				end
				S_MODE: begin
					mem_ras_n_o <= 1'b0;
					mem_cas_n_o <= 1'b0;
					mem_we_n_o  <= 1'b0;
					mem_ba_o    <= {1'b0, paddr_q[BA_LSB]};
					mem_addr_o  <= paddr_q[11:0];
				end
				S_REF: begin
					mem_ras_n_o <= 1'b0;
					mem_cas_n_o <= 1'b0;
				end
				S_PRE: begin
					mem_ras_n_o <= 1'b0;
					mem_we_n_o  <= 1'b0;
					mem_addr_o  <= 12'h000;
					mem_addr_o[AUTOCLOSE_BIT] <= 1'b1;
				end
				S_BST: mem_we_n_o <= 1'b0;
				default: ;
			endcase
		end
	end
end

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		user_refresh_ack_o <= 1'b0;
	end else if (ce_i) begin
		user_refresh_ack_o <= tick && st_d == S_REF && st_q != S_REF;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Mode settings kept for the data engines

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		bl_q               <= BL_RESET;
		cl_q               <= CL_RESET;
		test_mode_select_o <= 1'b0;
	end else if (tick && st_d == S_MODE && st_q != S_MODE && !paddr_q[BA_LSB]) begin
		if (paddr_q[MODE_BL_LSB +: 3] inside {BL_CODE_2, BL_CODE_4, BL_CODE_8}) begin
			bl_q <= paddr_q[MODE_BL_LSB +: 3];
		end
		if (paddr_q[MODE_CL_LSB +: 3] inside {CL_CODE_2, CL_CODE_25, CL_CODE_3}) begin
			cl_q <= paddr_q[MODE_CL_LSB +: 3];
		end
		test_mode_select_o <= paddr_q[MODE_TM_BIT];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Write engine: data a quarter cycle ahead of each strobe edge

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		wcnt_q            <= 6'd0;
		wr_busy_q         <= 1'b0;
		wbuf_q            <= '0;
		user_wdata_take_o <= 1'b0;
		mem_dq_o          <= '0;
		mem_dq_oe_o       <= 1'b0;
		mem_dqs_o         <= '0;
		mem_dqs_oe_o      <= 1'b0;
	end else if (ce_i) begin
		user_wdata_take_o <= accept && cmd_q == CMD_WRITE_AC;
		if (accept) begin
			wbuf_q <= wdata_q;
		end
		if (tick && st_d == S_WRITE && st_q != S_WRITE) begin
			wcnt_q    <= 6'd0;
			wr_busy_q <= 1'b1;
		end else if (tick && st_d == S_BST && wr_busy_q) begin
			wr_busy_q    <= 1'b0;
			mem_dq_oe_o  <= 1'b0;
			mem_dqs_oe_o <= 1'b0;
		end else if (wr_busy_q) begin
			wcnt_q <= wcnt_q + 6'd1;
			if (wcnt_q == 6'(WR_DQS_ON - 1)) begin
				mem_dqs_oe_o <= 1'b1;
				mem_dqs_o    <= '0;
			end
			if (wcnt_q >= 6'(WR_DQ_ON - 1) && wcnt_q < 6'(WR_DQ_ON - 1) + {beats, 1'b0} &&
			    wcnt_q[0] == 1'(WR_DQ_ON - 1)) begin
				mem_dq_oe_o <= 1'b1;
				mem_dq_o    <= wcnt_q[1] ? wbuf_q[DQ_W-1:0] : wbuf_q[2*DQ_W-1:DQ_W];
			end
			if (wcnt_q == 6'(WR_DQ_ON - 1) + {beats, 1'b0}) begin
				mem_dq_oe_o <= 1'b0;
			end
			if (wcnt_q >= 6'(WR_DQS_FIRST - 1) && wcnt_q < 6'(WR_DQS_FIRST - 1) + {beats, 1'b0} &&
			    wcnt_q[0] == 1'(WR_DQS_FIRST - 1)) begin
				mem_dqs_o <= ~mem_dqs_o;
			end
			if (wcnt_q == 6'(WR_DQS_FIRST - 1) + {beats, 1'b0}) begin
				mem_dqs_oe_o <= 1'b0;
				wr_busy_q    <= 1'b0;
			end
			// Next user word requested one pair ahead of its first beat
			user_wdata_take_o <= wcnt_q[1:0] == 2'd0 && wcnt_q != 6'd0 &&
			                     wcnt_q < {beats, 1'b0};
			if (wcnt_q[1:0] == 2'd2 && wcnt_q != 6'd2 && wcnt_q < {beats, 1'b0}) begin
				wbuf_q <= wdata_q;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read engine: pins sampled by the system clock, strobe not used

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		dq_s1_q <= '0;
		dq_s2_q <= '0;
		dq_s3_q <= '0;
	end else if (ce_i) begin
		dq_s1_q <= mem_dq_i;
		dq_s2_q <= dq_s1_q;
		dq_s3_q <= dq_s2_q;
	end
end

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		rcnt_q             <= 6'd0;
		rd_busy_q          <= 1'b0;
		rbeat_q            <= 5'd0;
		rhi_q              <= '0;
		user_rdata_o       <= '0;
		user_rdata_valid_o <= 1'b0;
	end else if (ce_i) begin
		user_rdata_valid_o <= 1'b0;
		if (tick && st_d == S_READ && st_q != S_READ) begin
			rcnt_q    <= 6'd0;
			rbeat_q   <= 5'd0;
			rd_busy_q <= 1'b1;
		end else if (rd_busy_q) begin
			rcnt_q <= rcnt_q + 6'd1;
			// Each beat taken from the third sync stage at a fixed count after the read command
			if (rcnt_q == 6'(RD_CMD_RISE + RD_SYNC) + {clh[4:0], 1'b0} +
			    {rbeat_q, 1'b0}) begin
				rbeat_q <= rbeat_q + 5'd1;
				if (rbeat_q[0]) begin
					user_rdata_o       <= {rhi_q, dq_s3_q};
					user_rdata_valid_o <= 1'b1;
				end else begin
					rhi_q <= dq_s3_q;
				end
				if (rbeat_q + 5'd1 == beats) begin
					rd_busy_q <= 1'b0;
				end
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Clock feedback watch: edges counted after a three-stage sync

always_ff @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		fb_q                    <= 3'd0;
		fb_cnt_q                <= 3'd0;
		fb_lvl_q                <= 1'b0;
		clock_feedback_locked_o <= 1'b0;
	end else if (ce_i) begin
		fb_q <= {fb_q[1:0], clock_feedback_in_i};
		// An edge counts once the last two stages agree on the new level
		if (fb_q[2] == fb_q[1] && fb_q[2] != fb_lvl_q) begin
			fb_lvl_q <= fb_q[2];
			if (fb_cnt_q != 3'(FB_LOCK_EDGES)) begin
				fb_cnt_q <= fb_cnt_q + 3'd1;
			end
		end
		clock_feedback_locked_o <= fb_cnt_q == 3'(FB_LOCK_EDGES);
	end
end

endmodule

// >>> design/ddc_pkg.sv
/*
 DDR SDRAM controller package: command codes, address fields, mode codes,
 reset values, sequencer states and timing counts.
 Assumes a system clock four times the memory clock rate.
*/
package ddc_pkg;
	localparam int         CMD_W          = 7;
	localparam logic [6:0] CMD_NOP        = 7'h01;
	localparam logic [6:0] CMD_MODE_LOAD  = 7'h02;
	localparam logic [6:0] CMD_READ_AC    = 7'h04;
	localparam logic [6:0] CMD_WRITE_AC   = 7'h08;
	localparam logic [6:0] CMD_PRECHARGE  = 7'h10;
	localparam logic [6:0] CMD_REFRESH    = 7'h20;
	localparam logic [6:0] CMD_BURST_STOP = 7'h40;
	localparam int         UADDR_W        = 22;
	localparam int         BA_LSB         = 20;
	localparam int         ROW_LSB        = 8;
	localparam int         COL_W          = 8;
	localparam int         MODE_BL_LSB    = 0;
	localparam int         MODE_CL_LSB    = 4;
	localparam int         MODE_TM_BIT    = 7;
	localparam int         AUTOCLOSE_BIT  = 10;
	localparam logic [2:0] BL_CODE_2      = 3'h1;
	localparam logic [2:0] BL_CODE_4      = 3'h2;
	localparam logic [2:0] BL_CODE_8      = 3'h3;
	localparam logic [2:0] CL_CODE_2      = 3'h2;
	localparam logic [2:0] CL_CODE_25     = 3'h6;
	localparam logic [2:0] CL_CODE_3      = 3'h3;
	localparam logic [2:0] BL_RESET       = BL_CODE_4;
	localparam logic [2:0] CL_RESET       = CL_CODE_3;
	localparam int         SYS_CLK_MHZ    = 100;
	localparam int         MEM_CLK_DOC_MHZ = 133;
	localparam int         PHASES         = 4;
	localparam int         MEM_CLK_MHZ    = SYS_CLK_MHZ / PHASES;
	localparam int         RCD_CYCLES     = 3;
	localparam int         WR_DQS_ON      = 4;
	localparam int         WR_DQ_ON       = 5;
	localparam int         WR_DQS_FIRST   = 6;
	localparam int         RD_CMD_RISE    = 2;
	localparam int         RD_SYNC        = 3;
	localparam int         FB_LOCK_EDGES  = 4;
	typedef enum logic [10:0] {
		S_IDLE    = 11'h001,
		S_ACT     = 11'h002,
		S_RCD     = 11'h004,
		S_READ    = 11'h008,
		S_RD_DATA = 11'h010,
		S_WRITE   = 11'h020,
		S_WR_DATA = 11'h040,
		S_MODE    = 11'h080,
		S_REF     = 11'h100,
		S_PRE     = 11'h200,
		S_BST     = 11'h400
	} ddc_state_t;
endpackage

// >>> test/ddc_ctrl_sva.sv
/*
 Checker for command, strobe and user-port timing of the controller.
 Assumes it is bound to ddc_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module ddc_ctrl_sva import ddc_pkg::*; #(
	parameter int DQ_W  = 64,
	parameter int DQS_W = DQ_W / 32
) (
	input wire logic               clk_sys_i,
	input wire logic               rst_i,
	input wire logic [CMD_W-1:0]   user_cmd_i,
	input wire logic               user_cmd_ready_o,
	input wire logic               user_rdata_valid_o,
	input wire logic               user_refresh_ack_o,
	input wire logic               mem_clk_o,
	input wire logic               mem_clk_n_o,
	input wire logic               mem_cke_o,
	input wire logic               mem_cs_n_o,
	input wire logic               mem_ras_n_o,
	input wire logic               mem_cas_n_o,
	input wire logic               mem_we_n_o,
	input wire logic [11:0]        mem_addr_o,
	input wire logic [DQ_W-1:0]    mem_dq_o,
	input wire logic               mem_dq_oe_o,
	input wire logic [DQS_W-1:0]   mem_dqs_o,
	input wire logic               mem_dqs_oe_o
);
////////////////////////////////////////////////////////////
	wire act_w   = !mem_cs_n_o && !mem_ras_n_o && mem_cas_n_o && mem_we_n_o;
	wire acc_w   = !mem_cs_n_o && mem_ras_n_o && !mem_cas_n_o;
	wire wr_w    = acc_w && !mem_we_n_o;
	wire pre_w   = !mem_cs_n_o && !mem_ras_n_o && mem_cas_n_o && !mem_we_n_o;
	wire bst_w   = !mem_cs_n_o && mem_ras_n_o && mem_cas_n_o && !mem_we_n_o;
	wire legal_w = $onehot(user_cmd_i) && user_cmd_i != CMD_NOP && user_cmd_i != CMD_BURST_STOP;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_reset_idle: assert property ($fell(rst_i) |-> mem_ras_n_o && mem_cas_n_o && mem_we_n_o
		&& !mem_cke_o && !user_rdata_valid_o) else $error("pins not idle after reset");
	a_clock_pair: assert property (mem_clk_n_o != mem_clk_o) else $error("clock pair not complementary");
	a_cmd_on_fall: assert property ($changed({mem_ras_n_o, mem_cas_n_o, mem_we_n_o, mem_addr_o})
		|-> $fell(mem_clk_o)) else $error("command changed off falling clock");
	a_act_first: assert property ($rose(acc_w) |-> $past(act_w, 12))
		else $error("access without activate three cycles before");
	a_autoclose_bit: assert property ((acc_w || pre_w) |-> mem_addr_o[AUTOCLOSE_BIT])
		else $error("autoclose bit low");
	a_strobe_pre: assert property ($rose(wr_w) |-> !mem_dqs_oe_o ##4 (mem_dqs_oe_o && mem_dqs_o == '0))
		else $error("strobe preamble wrong");
	a_data_first: assert property ($rose(wr_w) |-> ##5 (mem_dq_oe_o && mem_dqs_o == '0) ##1 (mem_dqs_o == '1))
		else $error("first write beat misplaced");
	a_strobe_centre: assert property ((mem_dq_oe_o && $past(mem_dq_oe_o) && $changed(mem_dq_o))
		|-> $stable(mem_dqs_o)) else $error("strobe moved with data");
	a_valid_pulse: assert property (user_rdata_valid_o |=> !user_rdata_valid_o)
		else $error("read valid longer than one cycle");
	a_take_ready: assert property ((user_cmd_ready_o && legal_w) |-> ##2 !user_cmd_ready_o)
		else $error("command not taken");
	a_ack_pulse: assert property (user_refresh_ack_o |=> !user_refresh_ack_o)
		else $error("refresh ack longer than one cycle");
	a_stop_ends: assert property ($rose(bst_w) |-> !mem_dq_oe_o && !mem_dqs_oe_o)
		else $error("write drive left on after burst stop");
endmodule

bind ddc_ctrl ddc_ctrl_sva #(.DQ_W(DQ_W), .DQS_W(DQS_W)) ddc_ctrl_sva_i (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .user_cmd_i(user_cmd_i), .user_cmd_ready_o(user_cmd_ready_o),
	.user_rdata_valid_o(user_rdata_valid_o), .user_refresh_ack_o(user_refresh_ack_o),
	.mem_clk_o(mem_clk_o), .mem_clk_n_o(mem_clk_n_o), .mem_cke_o(mem_cke_o), .mem_cs_n_o(mem_cs_n_o),
	.mem_ras_n_o(mem_ras_n_o), .mem_cas_n_o(mem_cas_n_o), .mem_we_n_o(mem_we_n_o), .mem_addr_o(mem_addr_o),
	.mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o), .mem_dqs_o(mem_dqs_o), .mem_dqs_oe_o(mem_dqs_oe_o)
);

// >>> test/ddc_mem_model.sv
/*
 Behavioural DDR memory: snoops mode loads, stores write beats, returns reads.
 Assumes the controller's sys/4 memory clock and its command timing.
*/
`timescale 1ns/1ps
module ddc_mem_model (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        ras_n_i,
	input  wire logic        cas_n_i,
	input  wire logic        we_n_i,
	input  wire logic [1:0]  ba_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [63:0] dq_i,
	input  wire logic        dq_oe_i,
	input  wire logic [1:0]  dqs_i,
	input  wire logic        dqs_oe_i,
	output logic      [63:0] dq_o,
	output logic      [1:0]  dqs_o
);
////////////////////////////////////////////////////////////
	logic [63:0] store_q [0:1023];
	logic [9:0]  rkey_q;
	logic [9:0]  wkey_q;
	logic        rd_q;
	logic        wr_q;
	logic [1:0]  dqs_q;
	int          rs_q;
	int          wj_q;
	int          bl_q;
	int          clh_q;
	int          k;
	wire rd_w   = ras_n_i && !cas_n_i && we_n_i;
	wire wr_w   = ras_n_i && !cas_n_i && !we_n_i;
	wire mode_w = !ras_n_i && !cas_n_i && !we_n_i && ba_i == 2'h0;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rs_q  <= 999;
			wj_q  <= 8;
			bl_q  <= 4;
			clh_q <= 6;
		end else begin
			rd_q  <= rd_w;
			wr_q  <= wr_w;
			dqs_q <= dqs_i;
			rs_q  <= rs_q + 1;
			if (rd_w && !rd_q) begin
				rs_q   <= 1;
				rkey_q <= {ba_i, addr_i[7:0]};
			end
			if (wr_w && !wr_q) begin
				wj_q   <= 0;
				wkey_q <= {ba_i, addr_i[7:0]};
			end else if (dqs_oe_i && dq_oe_i && dqs_i != dqs_q && wj_q < bl_q) begin
				store_q[10'(wkey_q + wj_q)] <= dq_i;
				wj_q <= wj_q + 1;
			end
			if (mode_w) begin
				bl_q  <= 1 << addr_i[2:0];
				clh_q <= (addr_i[6:4] == 3'h2) ? 4 : (addr_i[6:4] == 3'h6) ? 5 : 6;
			end
		end
	end

	// First beat one read latency after the sampling clock edge, two sys cycles a beat
	always_comb begin
		k = (rs_q - 2 - 2 * clh_q) / 2;
		dqs_o = {2{rs_q[0]}};
		if (rs_q >= 2 + 2 * clh_q && k < bl_q) begin
			dq_o = store_q[10'(rkey_q + k)];
		end else begin
			dq_o = {8{rs_q[7:0]}} ^ 64'h5a5a_a5a5_3c3c_c3c3;
		end
	end
endmodule

// >>> test/tb.sv
/*
 Self-checking bench: refused codes, refresh, precharge, test mode and
 write/read-back over every burst length and read latency.
 Assumes ddc_mem_model on the memory pins.
*/
`timescale 1ns/1ps
module tb import ddc_pkg::*;;
////////////////////////////////////////////////////////////
	logic          clk_sys_i = 0;
	logic          rst_i = 1;
	logic          ce_i = 1;
	logic          fb_clk = 0;
	logic [6:0]    user_cmd_i = CMD_NOP;
	logic [21:0]   user_addr_i = '0;
	logic [127:0]  user_wdata_i = '0;
	logic          ready, take, valid, ack, tmode, locked;
	logic          mclk, mclk_n, cke, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_oe;
	logic [127:0]  rdata;
	logic [1:0]    ba, mask, dqs_out, dqs_in;
	logic [11:0]   maddr;
	logic [63:0]   dq_out, dq_in;
	logic [127:0]  exp_q [$];
	logic [127:0]  wr_words [0:3];
	logic [31:0]   rng = 32'h51;
	logic [2:0]    cl_codes [0:2] = '{CL_CODE_2, CL_CODE_25, CL_CODE_3};
	logic [6:0]    bad_codes [0:3] = '{7'h03, CMD_NOP, CMD_BURST_STOP, 7'h00};
	logic [21:0]   a;
	int            err_count = 0;
	int            compares = 0;
	int            widx, ack_n, ack0;

	ddc_ctrl ddc_ctrl_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .user_cmd_i(user_cmd_i),
		.user_addr_i(user_addr_i), .user_wdata_i(user_wdata_i), .user_cmd_ready_o(ready),
		.user_wdata_take_o(take), .user_rdata_o(rdata), .user_rdata_valid_o(valid),
		.user_refresh_ack_o(ack), .test_mode_select_o(tmode), .clock_feedback_in_i(fb_clk),
		.clock_feedback_locked_o(locked), .mem_clk_o(mclk), .mem_clk_n_o(mclk_n), .mem_cke_o(cke),
		.mem_cs_n_o(cs_n), .mem_ras_n_o(ras_n), .mem_cas_n_o(cas_n), .mem_we_n_o(we_n), .mem_ba_o(ba),
		.mem_addr_o(maddr), .mem_byte_mask_o(mask), .mem_dq_i(dq_in), .mem_dq_o(dq_out),
		.mem_dq_oe_o(dq_oe), .mem_dqs_i(dqs_in), .mem_dqs_o(dqs_out), .mem_dqs_oe_o(dqs_oe));
	ddc_mem_model ddc_mem_model_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ras_n_i(ras_n), .cas_n_i(cas_n),
		.we_n_i(we_n), .ba_i(ba), .addr_i(maddr), .dq_i(dq_out), .dq_oe_i(dq_oe), .dqs_i(dqs_out),
		.dqs_oe_i(dqs_oe), .dq_o(dq_in), .dqs_o(dqs_in));

	initial forever #5 clk_sys_i = ~clk_sys_i;
	initial begin
		#3;
		forever #40 fb_clk = ~fb_clk;
	end

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic final_report();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(string n, logic [127:0] e, logic [127:0] g);
		compares++;
		if (e !== g) begin
			err_count++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic step(int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic issue(logic [6:0] c, logic [21:0] ad);
		int i;
		for (i = 0; i < 500 && ready !== 1'b1; i++) step(1);
		if (i == 500) begin
			check("ready_wait", 1, 0);
			final_report();
		end
		user_cmd_i = c;
		user_addr_i = ad;
		step(1);
		user_cmd_i = CMD_NOP;
		step(2);
	endtask

	// Next word is presented the cycle after each take pulse while widx is below 3
	always @(posedge clk_sys_i) begin
		if (take === 1'b1 && widx < 3) begin
			#1;
			widx++;
			user_wdata_i = wr_words[widx];
		end
	end

	always begin
		@(posedge clk_sys_i);
		#2;
		if (ack === 1'b1) ack_n++;
		if (valid === 1'b1) begin
			if (exp_q.size() == 0) check("rdata_extra", 0, 1);
			else check("rdata", exp_q.pop_front(), rdata);
		end
	end

	initial begin
		repeat (2) @(posedge clk_sys_i);
		#1 rst_i = 0;
		step(2);
		foreach (bad_codes[i]) begin
			user_cmd_i = bad_codes[i];
			step(4);
			check("ready_refused", 1, ready);
		end
		user_cmd_i = CMD_NOP;
		ack0 = ack_n;
		issue(CMD_REFRESH, '0);
		issue(CMD_PRECHARGE, '0);
		check("refresh_ack", 128'(ack0 + 1), 128'(ack_n));
		issue(CMD_MODE_LOAD, 22'h0000b2);
		issue(CMD_NOP, '0);
		check("test_mode_on", 1, tmode);
		for (int b = 1; b <= 3; b++) begin
			for (int c = 0; c < 3; c++) begin
				issue(CMD_MODE_LOAD, 22'({1'b0, cl_codes[c], 1'(c), 3'(b)}));
				for (int w = 0; w < 4; w++) wr_words[w] = {xs(), xs(), xs(), xs()};
				a = {2'(b), 12'(xs()), 8'(8 * c)};
				widx = 0;
				user_wdata_i = wr_words[0];
				issue(CMD_WRITE_AC, a);
				for (int w = 0; w < (1 << b) / 2; w++) exp_q.push_back(wr_words[w]);
				issue(CMD_READ_AC, a);
				issue(CMD_NOP, '0);
				step(8);
			end
		end
		widx = 0;
		issue(CMD_WRITE_AC, a);
		step(8);
		user_cmd_i = CMD_BURST_STOP;
		step(1);
		user_cmd_i = CMD_NOP;
		issue(CMD_NOP, '0);
		check("test_mode_off", 0, tmode);
		check("byte_mask", 0, mask);
		check("fb_locked", 1, locked);
		check("pending_reads", 0, 128'(exp_q.size()));
		final_report();
	end
endmodule
